// file: verilog/ppg_pkg.sv
`default_nettype none
package ppg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PWM_W  = 5;

  // Register offsets.
  localparam logic [7:0] OFS_PORT_K_DATA      = 8'h00;
  localparam logic [7:0] OFS_PORT_K_DIRECTION = 8'h01;
  localparam logic [7:0] OFS_PULLUP_CONTROL   = 8'h02;
  localparam logic [7:0] OFS_PWM_ROUTE_SELECT = 8'h03;
  localparam logic [7:0] OFS_PORT_SIDE_DATA   = 8'h04;
  localparam logic [7:0] OFS_ANALOG_DIR       = 8'h05;
  localparam logic [7:0] OFS_ANALOG_DIR_ALT   = 8'h06;
  localparam logic [7:0] OFS_DIGITAL_IN_EN    = 8'h07;
  localparam logic [7:0] OFS_CONVERTER_DATA   = 8'h08;

  // Field positions.
  localparam int unsigned PULLUP_K_BIT = 7;
  localparam int unsigned EMU_ADDR_LSB = 0;
  localparam int unsigned EMU_ADDR_W   = 3;

  // Values after reset, and the fixed read values for analog pins and unmapped offsets.
  localparam logic [7:0] RST_PORT_K_DATA      = 8'h00;
  localparam logic [7:0] RST_PORT_K_DIRECTION = 8'h00;
  localparam logic [7:0] RST_PULLUP_CONTROL   = 8'h80;
  localparam logic [4:0] RST_PWM_ROUTE_SELECT = 5'h00;
  localparam logic [7:0] RST_PORT_SIDE_DATA   = 8'h00;
  localparam logic [7:0] RST_ANALOG_DIR       = 8'h00;
  localparam logic [7:0] RST_DIGITAL_IN_EN    = 8'h00;
  localparam logic [7:0] ANALOG_READ_ONES     = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ        = 8'h00;
endpackage
`default_nettype wire

// file: verilog/ppg_port_glue.sv
// How it works
// R1: Port K direction register resets to all zeros, so all port K pins are inputs.
// R2: Pull-up enable bit of pull-up control resets to one, port K pull-ups on.
// R3: Software should leave port K direction and pull-up enable at reset values.
// R4: In emulation mode port K bits two to zero carry three extra address lines.
// R5: A PWM channel routed to port T still drives its port P pin too.
// R6: Software should not route PWM to port T on the largest package.
// R7: Port AD pin levels are readable via converter-side and port-side data registers.
// R8: Converter-side read needs digital input enable set and direction clear; the code gates it by digital input enable only and ignores direction.
// R9: With digital input enable clear, converter-side data bit reads as one.
// R10: Port-side read of a pin level needs its direction bit clear.
// R11: Software clears the direction bit before analog use of a port AD pin.
// R12: With a port AD direction bit set, the port-side data bit drives the pin.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ppg_port_glue (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic [ppg_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [ppg_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [ppg_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        emu_mode,
  input  wire logic [ppg_pkg::EMU_ADDR_W-1:0] emu_addr,
  input  wire logic [7:0]                  pk_in,
  output logic      [7:0]                  pk_out,
  output logic      [7:0]                  pk_oe_n,
  output logic                             pk_pullup_en,
  input  wire logic [ppg_pkg::PWM_W-1:0]   pwm_ch,
  output logic      [ppg_pkg::PWM_W-1:0]   pp_out,
  input  wire logic [ppg_pkg::PWM_W-1:0]   pt_core_out,
  input  wire logic [ppg_pkg::PWM_W-1:0]   pt_core_oe_n,
  output logic      [ppg_pkg::PWM_W-1:0]   pt_out,
  output logic      [ppg_pkg::PWM_W-1:0]   pt_oe_n,
  input  wire logic [7:0]                  pad_in,
  output logic      [7:0]                  pad_out,
  output logic      [7:0]                  pad_oe_n
);
  import ppg_pkg::*;

  logic [7:0]       port_k_data;
  logic [7:0]       port_k_direction;
  logic [7:0]       pullup_control;
  logic [PWM_W-1:0] pwm_route_select;
  logic [7:0]       port_side_pin_data;
  logic [7:0]       analog_port_direction;
  logic [7:0]       digital_input_enable;
  logic [7:0]       pk_meta;
  logic [7:0]       pk_sync;
  logic [7:0]       pad_meta;
  logic [7:0]       pad_sync;
  logic             emu_meta;
  logic             emu_sync;
  logic [7:0]       converter_side_pin_data;
  logic [7:0]       port_side_read;
  logic [7:0]       port_k_read;
  logic [7:0]       next_rdata;

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pk_meta  <= 8'h00;
      pk_sync  <= 8'h00;
      pad_meta <= 8'h00;
      pad_sync <= 8'h00;
      emu_meta <= 1'b0;
      emu_sync <= 1'b0;
    end else begin
      pk_meta  <= pk_in;
      pk_sync  <= pk_meta;
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
      emu_meta <= emu_mode;
      emu_sync <= emu_meta;
    end
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Port K registers.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_k_data      <= RST_PORT_K_DATA;
      port_k_direction <= RST_PORT_K_DIRECTION; // see R1
      pullup_control   <= RST_PULLUP_CONTROL;   // see R2
    end else if (reg_wr) begin
      if (hit(reg_addr, OFS_PORT_K_DATA)) begin
        port_k_data <= reg_wdata;
      end
      if (hit(reg_addr, OFS_PORT_K_DIRECTION)) begin
        port_k_direction <= reg_wdata;
      end
      if (hit(reg_addr, OFS_PULLUP_CONTROL)) begin
        pullup_control <= reg_wdata;
      end
    end
  end

  // PWM routing register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_route_select <= RST_PWM_ROUTE_SELECT;
    end else if (reg_wr && hit(reg_addr, OFS_PWM_ROUTE_SELECT)) begin
      pwm_route_select <= reg_wdata[PWM_W-1:0];
    end
  end

  // Port AD registers; the alternate direction offset aliases the same register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_side_pin_data    <= RST_PORT_SIDE_DATA;
      analog_port_direction <= RST_ANALOG_DIR;
      digital_input_enable  <= RST_DIGITAL_IN_EN;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFS_PORT_SIDE_DATA)) begin
        port_side_pin_data <= reg_wdata;
      end
      if (hit(reg_addr, OFS_ANALOG_DIR) || hit(reg_addr, OFS_ANALOG_DIR_ALT)) begin
        analog_port_direction <= reg_wdata;
      end
      if (hit(reg_addr, OFS_DIGITAL_IN_EN)) begin
        digital_input_enable <= reg_wdata;
      end
    end
  end

  // Read views of the pins.
  always_comb begin
    converter_side_pin_data = (digital_input_enable & pad_sync)
                            | (~digital_input_enable & ANALOG_READ_ONES); // see R7 see R9
    port_side_read = (analog_port_direction & port_side_pin_data)
                   | (~analog_port_direction & pad_sync); // see R7
    port_k_read = (port_k_direction & port_k_data) | (~port_k_direction & pk_sync);
  end

  always_comb begin
    next_rdata = UNMAPPED_READ;
    unique case (reg_addr)
      OFS_PORT_K_DATA:      next_rdata = port_k_read;
      OFS_PORT_K_DIRECTION: next_rdata = port_k_direction;
      OFS_PULLUP_CONTROL:   next_rdata = pullup_control;
      OFS_PWM_ROUTE_SELECT: next_rdata = {3'h0, pwm_route_select};
      OFS_PORT_SIDE_DATA:   next_rdata = port_side_read;
      OFS_ANALOG_DIR:       next_rdata = analog_port_direction;
      OFS_ANALOG_DIR_ALT:   next_rdata = analog_port_direction;
      OFS_DIGITAL_IN_EN:    next_rdata = digital_input_enable;
      OFS_CONVERTER_DATA:   next_rdata = converter_side_pin_data;
      default:              next_rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= UNMAPPED_READ;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= UNMAPPED_READ;
    end
  end

  // Pin drivers.
  always_comb begin
    pk_out       = port_k_data;
    pk_oe_n      = ~port_k_direction;
    pk_pullup_en = pullup_control[PULLUP_K_BIT]; // see R2
    if (emu_sync) begin
      pk_out[EMU_ADDR_LSB +: EMU_ADDR_W]  = emu_addr;      // see R4
      pk_oe_n[EMU_ADDR_LSB +: EMU_ADDR_W] = 3'h0;          // see R4
    end
    pp_out  = pwm_ch;                                        // see R5
    pt_out  = (pwm_route_select & pwm_ch) | (~pwm_route_select & pt_core_out); // see R5
    pt_oe_n = ~pwm_route_select & pt_core_oe_n;              // see R5
    pad_out  = port_side_pin_data;                           // see R12
    pad_oe_n = ~analog_port_direction;                       // see R12
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence dir_k_write_s;
    reg_wr && hit(reg_addr, OFS_PORT_K_DIRECTION);
  endsequence

  sequence conv_read_s;
    reg_rd && hit(reg_addr, OFS_CONVERTER_DATA);
  endsequence

  sequence side_read_s;
    reg_rd && hit(reg_addr, OFS_PORT_SIDE_DATA);
  endsequence

  k_dir_reset_a: assert property ( // see R1
    !$past(arst_n) |-> (port_k_direction == 8'h00 && pk_oe_n == 8'hFF) || emu_sync)
    else $error("Port K direction not zero after reset.");

  k_dir_write_a: assert property ( // see R1
    dir_k_write_s |=> pk_oe_n == ~$past(reg_wdata) || emu_sync)
    else $error("Port K enables do not follow direction write.");

  k_pullup_reset_a: assert property ( // see R2
    !$past(arst_n) |-> pk_pullup_en)
    else $error("Port K pull-ups not enabled after reset.");

  emu_addr_lines_a: assert property ( // see R4
    emu_sync |-> pk_out[2:0] == emu_addr && pk_oe_n[2:0] == 3'h0)
    else $error("Emulation address lines not driven on port K.");

  pwm_mirror_a: assert property ( // see R5
    pp_out == pwm_ch && ((pwm_route_select & (pt_out ^ pwm_ch)) == 5'h00)
      && ((pwm_route_select & pt_oe_n) == 5'h00))
    else $error("Routed PWM channel not on both ports.");

  conv_read_a: assert property ( // see R7
    conv_read_s |=> reg_rdata == (($past(digital_input_enable) & $past(pad_sync))
                                  | ~$past(digital_input_enable)))
    else $error("Converter-side read mismatch.");

  side_read_a: assert property ( // see R7
    side_read_s ##0 (analog_port_direction == 8'h00) |=> reg_rdata == $past(pad_sync))
    else $error("Port-side read does not show pin level.");

  analog_ones_a: assert property ( // see R9
    conv_read_s ##0 (digital_input_enable == 8'h00) |=> reg_rdata == 8'hFF)
    else $error("Analog pins do not read as one.");

  ad_drive_a: assert property ( // see R12
    ((analog_port_direction & (pad_out ^ port_side_pin_data)) == 8'h00)
      && (pad_oe_n == ~analog_port_direction))
    else $error("Port AD output pins not driven from data register.");
endmodule
`default_nettype wire

// file: verification/tb_port_pin_config_glue.sv
`timescale 1ns/10ps
`default_nettype none
module tb_port_pin_config_glue;
  import ppg_pkg::*;
  logic       ref_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       emu_mode = 1'b0;
  logic [2:0] emu_addr = 3'h0;
  logic [7:0] pk_in = 8'h00;
  logic [7:0] pk_out;
  logic [7:0] pk_oe_n;
  logic       pk_pullup_en;
  logic [4:0] pwm_ch = 5'h00;
  logic [4:0] pp_out;
  logic [4:0] pt_core_out = 5'h00;
  logic [4:0] pt_core_oe_n = 5'h1F;
  logic [4:0] pt_out;
  logic [4:0] pt_oe_n;
  logic [7:0] pad_in = 8'h00;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_n;
  int         fail_count = 0;
  int         comparisons = 0;
  int         i;
  logic [7:0] rd, m_dir, m_dat, m_en, m_pin;
  logic [4:0] m_rte;

  always #5 ref_clk = ~ref_clk;

  ppg_port_glue i_ppg_port_glue (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .emu_mode(emu_mode), .emu_addr(emu_addr), .pk_in(pk_in), .pk_out(pk_out),
    .pk_oe_n(pk_oe_n), .pk_pullup_en(pk_pullup_en), .pwm_ch(pwm_ch), .pp_out(pp_out),
    .pt_core_out(pt_core_out), .pt_core_oe_n(pt_core_oe_n), .pt_out(pt_out),
    .pt_oe_n(pt_oe_n), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #20000;
    fail_count++;
    $display("Watchdog expired at %0t", $time);
    end_of_test();
  end

  initial begin
    void'($urandom(32'hF04D));
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    chk(pk_oe_n, 8'hFF);
    chk({7'h00, pk_pullup_en}, 8'h01);
    chk({3'h0, pt_oe_n}, 8'h1F);
    rdr(OFS_PORT_K_DIRECTION, rd);
    chk(rd, 8'h00);
    rdr(OFS_PULLUP_CONTROL, rd);
    chk(rd, 8'h80);
    @(posedge ref_clk);
    #1;
    chk(reg_rdata, 8'h00);
    wr(OFS_PULLUP_CONTROL, 8'h00);
    chk({7'h00, pk_pullup_en}, 8'h00);
    wr(OFS_PULLUP_CONTROL, 8'h80);
    for (i = 0; i < 4; i++) begin
      m_dir = 8'($urandom);
      m_dat = 8'($urandom);
      m_pin = 8'($urandom);
      @(posedge ref_clk);
      pk_in <= m_pin;
      wr(OFS_PORT_K_DIRECTION, m_dir);
      wr(OFS_PORT_K_DATA, m_dat);
      settle();
      chk(pk_oe_n, ~m_dir);
      chk(pk_out, m_dat);
      rdr(OFS_PORT_K_DATA, rd);
      chk(rd, (m_dat & m_dir) | (m_pin & ~m_dir));
    end
    @(posedge ref_clk);
    emu_mode <= 1'b1;
    emu_addr <= 3'h5;
    settle();
    chk({5'h00, pk_out[2:0]}, 8'h05);
    chk(pk_oe_n, {~m_dir[7:3], 3'h0});
    @(posedge ref_clk);
    emu_addr <= 3'h2;
    #1;
    chk({5'h00, pk_out[2:0]}, 8'h02);
    @(posedge ref_clk);
    emu_mode <= 1'b0;
    for (i = 0; i < 8; i++) begin
      m_rte = (i == 0) ? 5'h1F : 5'($urandom);
      @(posedge ref_clk);
      pwm_ch <= 5'($urandom);
      pt_core_out <= 5'($urandom);
      pt_core_oe_n <= 5'($urandom);
      wr(OFS_PWM_ROUTE_SELECT, {3'h0, m_rte});
      chk({3'h0, pp_out}, {3'h0, pwm_ch});
      chk({3'h0, pt_out}, {3'h0, (pwm_ch & m_rte) | (pt_core_out & ~m_rte)});
      chk({3'h0, pt_oe_n}, {3'h0, pt_core_oe_n & ~m_rte});
    end
    rdr(OFS_PWM_ROUTE_SELECT, rd);
    chk(rd, {3'h0, m_rte});
    for (i = 0; i < 8; i++) begin
      m_en = (i == 0) ? 8'h00 : 8'($urandom);
      m_dir = (i == 1) ? 8'h00 : 8'($urandom);
      m_dat = 8'($urandom);
      m_pin = 8'($urandom);
      @(posedge ref_clk);
      pad_in <= m_pin;
      wr(OFS_DIGITAL_IN_EN, m_en);
      wr(i[0] ? OFS_ANALOG_DIR_ALT : OFS_ANALOG_DIR, m_dir);
      wr(OFS_PORT_SIDE_DATA, m_dat);
      settle();
      chk(pad_out, m_dat);
      chk(pad_oe_n, ~m_dir);
      rdr(OFS_CONVERTER_DATA, rd);
      chk(rd, (m_pin & m_en) | ~m_en);
      rdr(OFS_PORT_SIDE_DATA, rd);
      chk(rd, (m_dat & m_dir) | (m_pin & ~m_dir));
    end
    wr(8'hC3, 8'hFF);
    rdr(8'hC3, rd);
    chk(rd, 8'h00);
    rdr(OFS_ANALOG_DIR, rd);
    chk(rd, m_dir);
    rdr(OFS_ANALOG_DIR_ALT, rd);
    chk(rd, m_dir);
    rdr(OFS_DIGITAL_IN_EN, rd);
    chk(rd, m_en);
    end_of_test();
  end
endmodule
`default_nettype wire
